// ===== logic/tapr_clkdiv.v
// Divider that makes the byte-rate transmit clock and its edge pulses
`include "tapr_map.vh"
`default_nettype none

module tapr_clkdiv (
    input wire clk,
    input wire nrst,
    output reg clk_level,
    output reg rise,
    output reg fall
);

    localparam integer HALF_INT = `TAPR_HDLC_HALF_CYC - 1;
    localparam [`TAPR_DIV_W-1:0] HALF_LAST = HALF_INT[`TAPR_DIV_W-1:0];

    reg [`TAPR_DIV_W-1:0] count;

    // ****************************************************************
    // Free-running half-period counter
    // ****************************************************************
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            count <= {`TAPR_DIV_W{1'b0}};
            clk_level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end
        else if (count == HALF_LAST)
        begin
            count <= {`TAPR_DIV_W{1'b0}};
            clk_level <= ~clk_level;
            rise <= ~clk_level;
            fall <= clk_level;
        end
        else
        begin
            count <= count + 1'b1;
            rise <= 1'b0;
            fall <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== logic/tapr_map.vh
// Register map, field positions, reset values and timing counts
`ifndef TAPR_MAP_VH
`define TAPR_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TAPR_OFS_CONFIG 8'h00
`define TAPR_OFS_ACTIVE 8'h04
`define TAPR_OFS_STATUS 8'h08
`define TAPR_OFS_CLEAR 8'h0c
`define TAPR_OFS_ENABLE 8'h10
`define TAPR_OFS_LCV_COUNT 8'h14
`define TAPR_OFS_EXZ_COUNT 8'h18
`define TAPR_OFS_CAPTURE 8'h1c
`define TAPR_OFS_COMMAND 8'h20

// ****************************************************************
// Configuration fields
// ****************************************************************
`define TAPR_CFG_ADD_EN 0
`define TAPR_CFG_MODE_LO 1
`define TAPR_CFG_MODE_HI 3
`define TAPR_CFG_LCV_FALL 4
`define TAPR_CFG_COUNT_EXZ 5
`define TAPR_CFG_W 6
`define TAPR_CFG_RESET 6'h00

// ****************************************************************
// Channel operating modes
// ****************************************************************
`define TAPR_MODE_STS1 3'h0
`define TAPR_MODE_SINGLE 3'h1
`define TAPR_MODE_DUAL 3'h2
`define TAPR_MODE_HDLC 3'h3
`define TAPR_MODE_ATM 3'h4

// ****************************************************************
// Status and interrupt bits
// ****************************************************************
`define TAPR_ST_AIS_P 0
`define TAPR_ST_LCV 1
`define TAPR_ST_EXZ 2
`define TAPR_ST_HDLC_BYTE 3
`define TAPR_ST_W 4
`define TAPR_ST_RESET 4'h0

// ****************************************************************
// Constants and timing
// ****************************************************************
`define TAPR_FLAG_OCTET 8'h7e
`define TAPR_CMD_CELL_SENT 0
`define TAPR_SYS_PERIOD_NS 8
`define TAPR_HDLC_PERIOD_NS 64
`define TAPR_HDLC_HALF_CYC ((`TAPR_HDLC_PERIOD_NS / `TAPR_SYS_PERIOD_NS) / 2)
`define TAPR_DIV_W 4
`define TAPR_CNT_W 16
`define TAPR_SYNC_W 12

`endif

// ===== logic/tapr_sync.v
// Two-stage synchroniser for a group of asynchronous pins
`default_nettype none

module tapr_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire nrst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    // ****************************************************************
    // One pair of flops per bit
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg stage1;
            reg stage2;
            always @(posedge clk)
            begin
                if (!nrst)
                begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end
                else
                begin
                    stage1 <= async_in[i];
                    stage2 <= stage1;
                end
            end
            assign sync_out[i] = stage2;
        end
    endgenerate

endmodule

`default_nettype wire

// ===== logic/tapr_top.v
// Shared add-bus pin role steering with APB registers
//
// The implementer's own choices: register access over APB and the register addresses.
`include "tapr_map.vh"
`default_nettype none

module tapr_top (
    input wire SYS_CLK,
    input wire NRST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire ADD_BUS_CHANNEL_CLOCK,
    input wire ALARM_SHARED_PIN,
    input wire RECEIVE_LINE_CLOCK,
    input wire HDLC_SEND_MESSAGE_CMD,
    input wire [7:0] SHARED_DATA_IN,
    output reg [7:0] SHARED_DATA_OUT,
    output reg [7:0] SHARED_DATA_OE,
    output reg HDLC_TX_CLOCK_OUT,
    output reg [7:0] PAYLOAD_BYTE,
    output reg PAYLOAD_STROBE,
    output reg PAYLOAD_ALARM,
    output reg NEG_RAIL_DATA,
    output reg NEG_RAIL_STROBE,
    output reg IRQ
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    wire [`TAPR_SYNC_W-1:0] sync_pins;
    wire add_clk_s;
    wire alarm_s;
    wire line_clk_s;
    wire send_msg_s;
    wire [7:0] data_s;
    wire div_level;
    wire div_rise;
    wire div_fall;
    reg add_clk_d;
    reg line_clk_d;
    reg hdlc_rise;
    reg hdlc_fall;
    reg [`TAPR_CFG_W-1:0] cfg;
    reg act_add_en;
    reg [2:0] act_mode;
    reg [`TAPR_ST_W-1:0] status;
    reg [`TAPR_ST_W-1:0] enable;
    reg [`TAPR_CNT_W-1:0] lcv_count;
    reg [`TAPR_CNT_W-1:0] exz_count;
    reg [7:0] neg_shift;
    reg [3:0] gfc_nibble;
    reg [3:0] gfc_shift;
    reg [1:0] gfc_pos;
    reg cell_pend;
    reg cell_flag;
    reg [`TAPR_ST_W-1:0] st_set;
    reg [`TAPR_ST_W-1:0] st_clr;
    reg [31:0] next_prdata;
    reg next_pslverr;
    wire add_fall;
    wire line_edge;
    wire role_add;
    wire role_hdlc;
    wire role_atm;
    wire role_single;
    wire role_dual;
    wire apb_done;
    wire wr_en;

    // ****************************************************************
    // Pin synchronisers and divider
    // ****************************************************************
    tapr_sync #(
        .WIDTH(`TAPR_SYNC_W)
    ) u_sync (
        .clk(SYS_CLK),
        .nrst(NRST),
        .async_in({ADD_BUS_CHANNEL_CLOCK, ALARM_SHARED_PIN,
            RECEIVE_LINE_CLOCK, HDLC_SEND_MESSAGE_CMD, SHARED_DATA_IN}),
        .sync_out(sync_pins)
    );

    tapr_clkdiv u_div (
        .clk(SYS_CLK),
        .nrst(NRST),
        .clk_level(div_level),
        .rise(div_rise),
        .fall(div_fall)
    );

    assign add_clk_s = sync_pins[11];
    assign alarm_s = sync_pins[10];
    assign line_clk_s = sync_pins[9];
    assign send_msg_s = sync_pins[8];
    assign data_s = sync_pins[7:0];

    // Clock and data share the same sync delay, so their timing holds
    assign add_fall = add_clk_d & ~add_clk_s;
    assign line_edge = cfg[`TAPR_CFG_LCV_FALL] ?
        (line_clk_d & ~line_clk_s) : (~line_clk_d & line_clk_s);

    // ****************************************************************
    // Role decode
    // ****************************************************************
    assign role_add = act_add_en;
    assign role_hdlc = ~act_add_en && act_mode == `TAPR_MODE_HDLC;
    assign role_atm = ~act_add_en && act_mode == `TAPR_MODE_ATM;
    assign role_single = ~act_add_en && act_mode == `TAPR_MODE_SINGLE;
    assign role_dual = ~act_add_en && act_mode == `TAPR_MODE_DUAL;

    // ****************************************************************
    // Edge history and transmit clock pin
    // ****************************************************************
    always @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            add_clk_d <= 1'b0;
            line_clk_d <= 1'b0;
            hdlc_rise <= 1'b0;
            hdlc_fall <= 1'b0;
            HDLC_TX_CLOCK_OUT <= 1'b0;
        end
        else
        begin
            add_clk_d <= add_clk_s;
            line_clk_d <= line_clk_s;
            // Pulses delayed so they line up with the pin edge
            hdlc_rise <= div_rise;
            hdlc_fall <= div_fall;
            // Clock only leaves the chip in HDLC or cell roles
            HDLC_TX_CLOCK_OUT <= (role_hdlc | role_atm) & div_level;
        end
    end

    // ****************************************************************
    // Active role, swapped only at a byte boundary
    // ****************************************************************
    // The transmit clock falling edge sits mid-byte for no role but the add bus,
    // whose latch cycle (add_fall) is skipped, so a change never splits a byte being latched.
    always @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            act_add_en <= 1'b0;
            act_mode <= `TAPR_MODE_STS1;
        end
        else if (hdlc_fall && !add_fall)
        begin
            act_add_en <= cfg[`TAPR_CFG_ADD_EN];
            act_mode <= cfg[`TAPR_CFG_MODE_HI:`TAPR_CFG_MODE_LO];
        end
    end

    // ****************************************************************
    // Payload path: add bus or HDLC input
    // ****************************************************************
    always @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            PAYLOAD_BYTE <= 8'h00;
            PAYLOAD_STROBE <= 1'b0;
            PAYLOAD_ALARM <= 1'b0;
        end
        else if (role_add && add_fall)
        begin
            PAYLOAD_BYTE <= data_s;
            PAYLOAD_STROBE <= 1'b1;
            PAYLOAD_ALARM <= alarm_s;
        end
        else if (role_hdlc && hdlc_rise)
        begin
            // Without send-message the line idles on flag octets
            PAYLOAD_BYTE <= send_msg_s ? data_s :
                `TAPR_FLAG_OCTET;
            PAYLOAD_STROBE <= 1'b1;
            PAYLOAD_ALARM <= 1'b0;
        end
        else
        begin
            PAYLOAD_STROBE <= 1'b0;
            PAYLOAD_ALARM <= 1'b0;
        end
    end

    // ****************************************************************
    // Receive line roles of the alarm pin
    // ****************************************************************
    // In STS-1 mode the pin is grounded on the board and ignored here.
    always @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            lcv_count <= {`TAPR_CNT_W{1'b0}};
            exz_count <= {`TAPR_CNT_W{1'b0}};
            neg_shift <= 8'h00;
            NEG_RAIL_DATA <= 1'b0;
            NEG_RAIL_STROBE <= 1'b0;
        end
        else
        begin
            NEG_RAIL_STROBE <= 1'b0;
            if (role_single && line_edge && alarm_s)
            begin
                if (cfg[`TAPR_CFG_COUNT_EXZ])
                    exz_count <= exz_count + 1'b1;
                else
                    lcv_count <= lcv_count + 1'b1;
            end
            if (role_dual && line_edge)
            begin
                NEG_RAIL_DATA <= alarm_s;
                NEG_RAIL_STROBE <= 1'b1;
                neg_shift <= {neg_shift[6:0], alarm_s};
            end
        end
    end

    // ****************************************************************
    // Cell interface roles
    // ****************************************************************
    always @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            gfc_pos <= 2'h0;
            gfc_shift <= 4'h0;
            gfc_nibble <= 4'h0;
            cell_pend <= 1'b0;
            cell_flag <= 1'b0;
            SHARED_DATA_OUT <= 8'h00;
            SHARED_DATA_OE <= 8'h00;
        end
        else
        begin
            if (role_atm && hdlc_rise)
            begin
                gfc_pos <= gfc_pos + 1'b1;
                gfc_shift <= {gfc_shift[2:0], data_s[1]};
                if (gfc_pos == 2'h3)
                    gfc_nibble <= {gfc_shift[2:0], data_s[1]};
                cell_flag <= cell_pend;
            end
            else if (!role_atm)
            begin
                gfc_pos <= 2'h0;
                cell_flag <= 1'b0;
            end
            // Request waits for the next clock so the flag spans a period
            if (wr_en && PADDR == `TAPR_OFS_COMMAND)
                cell_pend <= PWDATA[`TAPR_CMD_CELL_SENT];
            else if (role_atm && hdlc_rise)
                cell_pend <= 1'b0;
            SHARED_DATA_OUT <= {5'h00, cell_flag, 1'b0,
                role_atm && gfc_pos == 2'h0};
            SHARED_DATA_OE <= role_atm ? 8'h05 : 8'h00;
        end
    end

    // ****************************************************************
    // Events, status, interrupt
    // ****************************************************************
    always @*
    begin
        st_set = {`TAPR_ST_W{1'b0}};
        st_set[`TAPR_ST_AIS_P] = role_add & add_fall & alarm_s;
        st_set[`TAPR_ST_LCV] = role_single & line_edge & alarm_s &
            ~cfg[`TAPR_CFG_COUNT_EXZ];
        st_set[`TAPR_ST_EXZ] = role_single & line_edge & alarm_s &
            cfg[`TAPR_CFG_COUNT_EXZ];
        st_set[`TAPR_ST_HDLC_BYTE] = role_hdlc & hdlc_rise & send_msg_s;
        st_clr = {`TAPR_ST_W{1'b0}};
        if (wr_en && PADDR == `TAPR_OFS_CLEAR)
            st_clr = PWDATA[`TAPR_ST_W-1:0];
    end

    always @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            status <= `TAPR_ST_RESET;
            IRQ <= 1'b0;
        end
        else
        begin
            // A new event outranks a clear in the same cycle
            status <= (status & ~st_clr) | st_set;
            IRQ <= |(((status & ~st_clr) | st_set) & enable);
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // One wait state: PREADY rises on the second access cycle.
    assign apb_done = PSEL & PENABLE & PREADY;
    assign wr_en = apb_done & PWRITE;

    always @*
    begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        case (PADDR)
            `TAPR_OFS_CONFIG:
                next_prdata = {26'h0000000, cfg};
            `TAPR_OFS_ACTIVE:
                next_prdata = {28'h0000000, act_mode, act_add_en};
            `TAPR_OFS_STATUS:
                next_prdata = {28'h0000000, status};
            `TAPR_OFS_CLEAR:
                next_prdata = 32'h00000000;
            `TAPR_OFS_ENABLE:
                next_prdata = {28'h0000000, enable};
            `TAPR_OFS_LCV_COUNT:
                next_prdata = {16'h0000, lcv_count};
            `TAPR_OFS_EXZ_COUNT:
                next_prdata = {16'h0000, exz_count};
            `TAPR_OFS_CAPTURE:
                next_prdata = {12'h000, gfc_nibble, neg_shift, PAYLOAD_BYTE};
            `TAPR_OFS_COMMAND:
                next_prdata = {31'h00000000, cell_pend};
            default:
                next_pslverr = 1'b1;
        endcase
    end

    always @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
            cfg <= `TAPR_CFG_RESET;
            enable <= `TAPR_ST_RESET;
        end
        else
        begin
            PREADY <= PSEL & PENABLE & ~PREADY;
            if (PSEL && PENABLE && !PREADY)
            begin
                PRDATA <= PWRITE ? 32'h00000000 : next_prdata;
                PSLVERR <= next_pslverr;
            end
            else
            begin
                PRDATA <= 32'h00000000;
                PSLVERR <= 1'b0;
            end
            if (wr_en && PADDR == `TAPR_OFS_CONFIG)
                cfg <= PWDATA[`TAPR_CFG_W-1:0];
            if (wr_en && PADDR == `TAPR_OFS_ENABLE)
                enable <= PWDATA[`TAPR_ST_W-1:0];
        end
    end

endmodule

`default_nettype wire

// ===== verif/tapr_checker.sv
// Port-level assertions for the shared pin role block
`default_nettype none
module tapr_checker (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [31:0] PRDATA,
    input wire logic [7:0] PAYLOAD_BYTE,
    input wire logic PAYLOAD_STROBE,
    input wire logic PAYLOAD_ALARM,
    input wire logic HDLC_TX_CLOCK_OUT,
    input wire logic NEG_RAIL_STROBE,
    input wire logic [7:0] SHARED_DATA_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Properties
    // ****
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    chk_apb_wait: assert property (
        $rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
        else $error("ready not on second access cycle");
    chk_ready_once: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
        else $error("ready not a single access pulse");
    chk_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error response without ready");
    chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside the answer cycle");
    chk_strobe_pulse: assert property (
        PAYLOAD_STROBE |=> !PAYLOAD_STROBE)
        else $error("payload strobe longer than one cycle");
    chk_alarm_strobe: assert property (
        PAYLOAD_ALARM |-> PAYLOAD_STROBE)
        else $error("alarm flag without a byte");
    chk_byte_hold: assert property (
        !PAYLOAD_STROBE |-> $stable(PAYLOAD_BYTE))
        else $error("payload byte moved without strobe");
    chk_tx_clock_high: assert property (
        $rose(HDLC_TX_CLOCK_OUT) |->
        HDLC_TX_CLOCK_OUT [*4] ##1 !HDLC_TX_CLOCK_OUT)
        else $error("transmit clock high phase not four cycles");
    chk_rail_pulse: assert property (NEG_RAIL_STROBE |=> !NEG_RAIL_STROBE)
        else $error("rail strobe longer than one cycle");
    chk_oe_roles: assert property (
        SHARED_DATA_OE == 8'h00 || SHARED_DATA_OE == 8'h05)
        else $error("shared pins driven outside cell roles");
endmodule

bind tapr_top tapr_checker i_tapr_checker (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PRDATA(PRDATA), .PAYLOAD_BYTE(PAYLOAD_BYTE),
    .PAYLOAD_STROBE(PAYLOAD_STROBE), .PAYLOAD_ALARM(PAYLOAD_ALARM),
    .HDLC_TX_CLOCK_OUT(HDLC_TX_CLOCK_OUT),
    .NEG_RAIL_STROBE(NEG_RAIL_STROBE), .SHARED_DATA_OE(SHARED_DATA_OE));
`default_nettype wire

// ===== verif/tapr_partner.sv
// Upstream add-bus source: clock, byte and alarm strobe
`default_nettype none
module tapr_partner (
    input wire logic SYS_CLK,
    input wire logic run,
    input wire logic [7:0] byte_in,
    input wire logic alarm_in,
    output var logic taken,
    output var logic add_clk,
    output var logic [7:0] data,
    output var logic alarm
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    initial
    begin
        cnt = 4'h0;
        taken = 1'b0;
        add_clk = 1'b0;
        data = 8'h00;
        alarm = 1'b0;
    end
    // ****
    // Add clock of 20 cycles; stands low between bursts
    // ****
    always @(posedge SYS_CLK)
    begin
        taken <= 1'b0;
        cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
        if (cnt == 4'h9 && add_clk)
            add_clk <= 1'b0;
        else if (cnt == 4'h9 && run)
        begin
            add_clk <= 1'b1;
            data <= byte_in;
            alarm <= alarm_in;
            taken <= 1'b1;
        end
        else if (!add_clk && !run && cnt == 4'h4)
        begin
            data <= ~data; // Released bus must not echo the last byte
            alarm <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the shared pin role block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, tb_data = 8'h00, p_byte = 8'h00, nsh = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, r, seed = 32'h3f;
    logic lclk = 0, lcv = 0, line_sel = 0, hdlc_sel = 0, send = 0;
    logic p_run = 0, p_alarm = 0, watch = 0, err;
    wire logic [31:0] prdata;
    wire logic [7:0] dout, doe, pbyte, a_data, din;
    wire logic pready, pslverr, hclk, pstb, palm, irq, taken, aclk, a_pin;
    wire logic alarm_pin, nrd, nrs;
    logic [8:0] exp_q[$];
    int err_count = 0, tests_run = 0, hits, rails = 0;
    // Shared pins see our drive only where the design is not driving
    assign din = (doe & dout) | (~doe & (hdlc_sel ? tb_data : a_data));
    assign alarm_pin = line_sel ? lcv : a_pin;
    initial forever #4 sys_clk = ~sys_clk;
    tapr_partner i_tapr_partner (.SYS_CLK(sys_clk), .run(p_run),
        .byte_in(p_byte), .alarm_in(p_alarm), .taken(taken),
        .add_clk(aclk), .data(a_data), .alarm(a_pin));
    tapr_top i_tapr_top (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ADD_BUS_CHANNEL_CLOCK(aclk),
        .ALARM_SHARED_PIN(alarm_pin), .RECEIVE_LINE_CLOCK(lclk),
        .HDLC_SEND_MESSAGE_CMD(send), .SHARED_DATA_IN(din),
        .SHARED_DATA_OUT(dout), .SHARED_DATA_OE(doe),
        .HDLC_TX_CLOCK_OUT(hclk), .PAYLOAD_BYTE(pbyte),
        .PAYLOAD_STROBE(pstb), .PAYLOAD_ALARM(palm),
        .NEG_RAIL_DATA(nrd), .NEG_RAIL_STROBE(nrs), .IRQ(irq));
    // ****
    // Helpers
    // ****
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task final_report();
        $display("COUNTS tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task tmo();
        err_count++;
        $display("ERROR %0t wait ran out got %h exp %h", $time, 1'b0, 1'b1);
        final_report();
    endtask
    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_pay(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        repeat (20)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (pready !== 1'b1)
            tmo();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task set_cfg(input logic [31:0] v);
        apb(1'b1, 8'h00, v);
        repeat (4)
        begin
            apb(1'b0, 8'h04, 32'h0);
            if (rd === (v & 32'hf))
                break;
        end
        chk_reg(rd, v & 32'hf);
    endtask
    task wait_hclk(input logic v);
        repeat (20)
        begin
            @(posedge sys_clk);
            if (hclk === v)
                break;
        end
        if (hclk !== v)
            tmo();
    endtask
    task wait_q();
        repeat (300)
        begin
            @(posedge sys_clk);
            if (exp_q.size() == 0)
                break;
        end
        if (exp_q.size() != 0)
            tmo();
        watch <= 1'b0;
    endtask
    // ****
    // Payload monitor and main sequence
    // ****
    always @(posedge sys_clk)
        if (watch && pstb === 1'b1)
            chk_pay({palm, pbyte},
                exp_q.size() ? exp_q.pop_front() : 9'hx);
    // Rail samples only come in dual-rail mode
    always @(posedge sys_clk)
        rails += (nrs === 1'b1);
    initial
    begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk_reg(rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk_reg(rd, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        chk_reg({err, rd[30:0]}, 32'h80000000);
        chk_reg({24'h0, doe}, 32'h0);
        $display("TEST reset done");
        set_cfg(32'h1);
        watch <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            r = xs();
            p_byte <= r[7:0];
            p_alarm <= (i == 2 || i == 5);
            p_run <= 1'b1;
            exp_q.push_back({(i == 2 || i == 5), r[7:0]});
            repeat (40)
            begin
                @(posedge sys_clk);
                if (taken === 1'b1)
                    break;
            end
            if (taken !== 1'b1)
                tmo();
        end
        p_run <= 1'b0;
        wait_q();
        apb(1'b0, 8'h08, 32'h0);
        chk_reg(rd & 32'h1, 32'h1);
        apb(1'b1, 8'h0c, 32'hf);
        $display("TEST add bus done");
        set_cfg(32'h6);
        hdlc_sel <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            wait_hclk(1'b1);
            wait_hclk(1'b0);
            r = xs();
            send <= (i % 4 != 0);
            tb_data <= r[7:0];
            exp_q.push_back({1'b0, (i % 4 != 0) ? r[7:0] : 8'h7e});
            watch <= 1'b1;
        end
        wait_q();
        $display("TEST hdlc done");
        hdlc_sel <= 1'b0;
        set_cfg(32'h8);
        chk_reg({24'h0, doe}, 32'h5);
        apb(1'b1, 8'h20, 32'h1);
        repeat (30)
        begin
            @(posedge sys_clk);
            if (dout[2] === 1'b1)
                break;
        end
        chk_reg({31'h0, dout[2]}, 32'h1);
        repeat (40)
        begin
            @(posedge sys_clk);
            if (dout[0] === 1'b1)
                break;
        end
        chk_reg({31'h0, dout[0]}, 32'h1);
        $display("TEST cell port done");
        line_sel <= 1'b1;
        for (int p = 0; p < 3; p++)
        begin
            set_cfg(p == 2 ? 32'h4 : p ? 32'h32 : 32'h2);
            hits = 0;
            for (int k = 0; k < 12; k++)
            begin
                r = xs();
                lcv <= (k == 0) | r[0];
                hits += (k == 0) | r[0];
                nsh = {nsh[6:0], (k == 0) | r[0]};
                lclk <= p[0];
                repeat (10) @(posedge sys_clk);
                lclk <= ~p[0];
                repeat (10) @(posedge sys_clk);
            end
            repeat (10) @(posedge sys_clk);
            apb(1'b0, p == 2 ? 8'h1c : p ? 8'h18 : 8'h14, 32'h0);
            if (p == 2)
            begin
                chk_reg({16'h0, rd[15:8], 7'h0, nrd},
                    {16'h0, nsh, 7'h0, nsh[0]});
                chk_reg(rails, 32'hc);
            end
            else
                chk_reg(rd, hits);
        end
        chk_reg({24'h0, doe}, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk_reg(rd & 32'h6, 32'h6);
        chk_reg({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h10, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk_reg({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h0c, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk_reg({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk_reg(rd & 32'h6, 32'h4);
        $display("TEST line and interrupt done");
        final_report();
    end
endmodule
`default_nettype wire
